// ---- design/srt_pkg.sv ----
// Constants, types and reset state of the survey record serial transmitter
package srt_pkg;
	localparam int CLK_HZ = 40000000;
	localparam int BAUD_DEFAULT = 9600;
	localparam logic [15:0] BAUD_DIV_RESET = 16'(CLK_HZ / BAUD_DEFAULT);
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_CMD = 12'h004;
	localparam logic [11:0] OFS_START_STATION = 12'h008;
	localparam logic [11:0] OFS_RECORD_COUNT = 12'h00c;
	localparam logic [11:0] OFS_BAUD_DIV = 12'h010;
	localparam logic [11:0] OFS_STATUS = 12'h014;
	localparam logic [2:0] MEM_SEL = 3'h1;
	localparam int RECS = 8;
	localparam int WORDS_PER_REC = 16;
	localparam int MEM_WORDS = RECS * WORDS_PER_REC;
	localparam int REC_WORDS = 9;
	localparam logic [3:0] RECS_MAX = 4'h8;
	localparam int CTRL_CSV_BIT = 0;
	localparam int CTRL_SEEK_BIT = 1;
	localparam int CMD_START_BIT = 0;
	localparam int WD_FLAGS = 0;
	localparam int WD_STN_JDAY = 1;
	localparam int WD_DATE = 2;
	localparam int WD_TIME = 3;
	localparam int WD_FIELD = 4;
	localparam int WD_PTIME = 5;
	localparam int WD_PDATE = 6;
	localparam int WD_LAT = 7;
	localparam int WD_LON = 8;
	localparam int W0_FLAG = 31;
	localparam int W0_MODE = 30;
	localparam int W0_TRUNC = 29;
	localparam int W0_POS_VALID = 28;
	localparam int W0_LAT_NEG = 27;
	localparam int W0_LON_NEG = 26;
	localparam int W0_STATUS_LSB = 21;
	localparam int W0_LON_HUND = 20;
	localparam logic START_LEVEL = 1'b1;
	localparam logic PARITY_LEVEL = 1'b0;
	localparam logic STOP_LEVEL = 1'b0;
	localparam logic IDLE_LEVEL = 1'b0;
	localparam logic [3:0] FRAME_LEFT = 4'ha;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	localparam logic [6:0] CH_EOT = 7'h04;
	localparam logic [6:0] CH_CR = 7'h0d;
	localparam logic [6:0] CH_LF = 7'h0a;
	localparam logic [6:0] CH_SPACE = 7'h20;
	localparam logic [6:0] CH_STAR = 7'h2a;
	localparam logic [6:0] CH_COMMA = 7'h2c;
	localparam logic [6:0] CH_DOT = 7'h2e;
	localparam logic [6:0] CH_SLASH = 7'h2f;
	localparam logic [6:0] CH_COLON = 7'h3a;
	localparam logic [6:0] CH_MINUS = 7'h2d;
	localparam logic [6:0] CH_PLUS = 7'h2b;
	localparam HDR1_TEXT = "MODE,LINE,DATE,TIME,STATION,TRUNCATION,MAGFIELD,POSITION_LATITUDE,POSITION_LONGITUDE,POSITION_TIME,POSITION_DATE,SIGNAL,POSITION_STATUS,RESERVED";
	localparam int HDR1_LEN = $bits(HDR1_TEXT) / 8;
	// Model and version text is arbitrary
	localparam HDR2_TEXT = "#MAGTX v. 0.1";
	localparam int HDR2_LEN = $bits(HDR2_TEXT) / 8;
	typedef enum logic [2:0] {SQ_IDLE, SQ_SEEK, SQ_HDR1, SQ_HDR2, SQ_REC, SQ_EOT} srt_seq_e;
	typedef enum logic [4:0] {SG_END, SG_FLAG, SG_LINE3, SG_LINE5, SG_SPACE, SG_COMMA, SG_JDAY, SG_TIME6,
		SG_TIME8, SG_DATE, SG_STATION, SG_FIELD6, SG_FIELD7, SG_MODE, SG_TRUNC, SG_LAT, SG_LON,
		SG_PTIME, SG_PDATE, SG_STATUS, SG_CRLF} srt_seg_e;
	typedef struct packed {
		logic aw_ok;
		logic [11:0] aw_addr;
		logic w_ok;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic ctrl_csv;
		logic ctrl_seek;
		logic [11:0] start_station;
		logic [3:0] rec_count;
		logic [15:0] baud_div;
		srt_seq_e seq;
		logic csv;
		logic [3:0] rec;
		logic [4:0] seg;
		logic [7:0] k;
		logic tx_busy;
		logic [10:0] tx_shift;
		logic [3:0] tx_left;
		logic [15:0] baud_cnt;
		logic tx_line;
	} srt_state_s;
	localparam srt_state_s ST_RESET = '{aw_ok: 1'b0, aw_addr: 12'h000, w_ok: 1'b0, w_data: 32'h0,
		w_strb: 4'h0, bvalid: 1'b0, bresp: 2'h0, rvalid: 1'b0, rdata: 32'h0, rresp: 2'h0,
		ctrl_csv: 1'b0, ctrl_seek: 1'b0, start_station: 12'h000, rec_count: 4'h0,
		baud_div: BAUD_DIV_RESET, seq: SQ_IDLE, csv: 1'b0, rec: 4'h0, seg: 5'h00, k: 8'h00,
		tx_busy: 1'b0, tx_shift: 11'h000, tx_left: 4'h0, baud_cnt: 16'h0000, tx_line: IDLE_LEVEL};
endpackage : srt_pkg

// ---- design/srt_tx.sv ----
// Survey record dump formatter and serial transmitter with AXI4-Lite registers
// Notes on behaviour
// - Low clear-to-send holds off output; tie high when unused.
// - Every character opens with one start bit at logic 1.
// - Seven ASCII data bits follow the start bit.
// - One parity bit, always logic 0, follows the data.
// - Two stop bits at logic 0 close every character.
// - Fixed layout: 29 characters with flag, line, day, time, station, field, CR LF.
// - One end-of-transmission character ends every dump.
// - Dump starts at first record, or at the record matching a given station.
// - Comma layout first line lists the column names.
// - Comma layout second line is hash, model and version text.
// - Comma records carry fourteen fields in fixed order, commas, then CR LF.
// - Mode field is 0 for manual, 1 for automatic reading.
// - Console date mm/dd/yy and time hh:mm:ss, eight characters each.
// - Truncation is 0 for good, 1 for poor reading.
// - Field value is seven characters nnnnn.n.
// - Latitude signed in ten characters, longitude signed in eleven.
// - Position time hh:mm:ss then position date mm/dd/yy.
// - Position status is one character.
// - Signal and reserved fields are empty, only commas appear.
`timescale 1ns/1ps
module srt_tx (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [srt_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [srt_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cts,
	output logic txd
);
	import srt_pkg::*;

	srt_state_s st;
	srt_state_s nx;
	logic [31:0] mem [0:MEM_WORDS-1];
	logic [31:0] recw [0:REC_WORDS-1];
	logic mem_we;
	logic [6:0] mem_widx;
	logic [31:0] mem_wdata;
	logic busy;
	logic start_req;
	logic accept;
	logic ch_valid;
	logic [6:0] ch;
	srt_seg_e kind;
	logic [3:0] len;
	logic [31:0] merged;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic [6:0] dig(input logic [31:0] w, input int n);
		return {3'b011, w[n*4 +: 4]};
	endfunction : dig

	// Six packed digits shown as two-two-two with separators
	function automatic logic [6:0] sep8(input logic [31:0] w, input logic [3:0] k, input logic [6:0] sep);
		case (k)
			4'h0: return dig(w, 5);
			4'h1: return dig(w, 4);
			4'h3: return dig(w, 3);
			4'h4: return dig(w, 2);
			4'h6: return dig(w, 1);
			4'h7: return dig(w, 0);
			default: return sep;
		endcase
	endfunction : sep8

	function automatic srt_seg_e seg_at(input logic csv, input logic [4:0] i);
		if (!csv) begin
			case (i)
				5'h00: return SG_FLAG;
				5'h01: return SG_LINE3;
				5'h02: return SG_SPACE;
				5'h03: return SG_JDAY;
				5'h04: return SG_SPACE;
				5'h05: return SG_TIME6;
				5'h06: return SG_SPACE;
				5'h07: return SG_STATION;
				5'h08: return SG_SPACE;
				5'h09: return SG_FIELD6;
				5'h0a: return SG_CRLF;
				default: return SG_END;
			endcase
		end
		case (i)
			5'h00: return SG_MODE;
			5'h02: return SG_LINE5;
			5'h04: return SG_DATE;
			5'h06: return SG_TIME8;
			5'h08: return SG_STATION;
			5'h0a: return SG_TRUNC;
			5'h0c: return SG_FIELD7;
			5'h0e: return SG_LAT;
			5'h10: return SG_LON;
			5'h12: return SG_PTIME;
			5'h14: return SG_PDATE;
			5'h17: return SG_STATUS;
			5'h19: return SG_CRLF;
			5'h01, 5'h03, 5'h05, 5'h07, 5'h09, 5'h0b, 5'h0d, 5'h0f, 5'h11, 5'h13, 5'h15, 5'h16, 5'h18: return SG_COMMA;
			default: return SG_END;
		endcase
	endfunction : seg_at

	function automatic logic [3:0] seg_len(input srt_seg_e kd, input logic pos_valid);
		case (kd)
			SG_FLAG, SG_SPACE, SG_COMMA, SG_MODE, SG_TRUNC, SG_STATUS: return 4'h1;
			SG_CRLF: return 4'h2;
			SG_LINE3, SG_JDAY: return 4'h3;
			SG_STATION: return 4'h4;
			SG_LINE5: return 4'h5;
			SG_TIME6, SG_FIELD6: return 4'h6;
			SG_FIELD7: return 4'h7;
			SG_TIME8, SG_DATE: return 4'h8;
			SG_PTIME, SG_PDATE: return pos_valid ? 4'h8 : 4'h0;
			SG_LAT: return pos_valid ? 4'ha : 4'h0;
			SG_LON: return pos_valid ? 4'hb : 4'h0;
			default: return 4'h0;
		endcase
	endfunction : seg_len

	function automatic logic [6:0] seg_char(input srt_seg_e kd, input logic [3:0] k, input logic [31:0] w0,
		input logic [31:0] w1, input logic [31:0] w2, input logic [31:0] w3, input logic [31:0] w4,
		input logic [31:0] w5, input logic [31:0] w6, input logic [31:0] w7, input logic [31:0] w8);
		int ki;
		ki = int'(k);
		case (kd)
			SG_FLAG: return w0[W0_FLAG] ? CH_STAR : CH_SPACE;
			SG_LINE3: return dig(w0, 2 - ki);
			SG_LINE5: return dig(w0, 4 - ki);
			SG_SPACE: return CH_SPACE;
			SG_COMMA: return CH_COMMA;
			SG_JDAY: return dig(w1, 2 - ki);
			SG_STATION: return dig(w1, 7 - ki);
			SG_TIME6: return dig(w3, 5 - ki);
			SG_TIME8: return sep8(w3, k, CH_COLON);
			SG_DATE: return sep8(w2, k, CH_SLASH);
			SG_FIELD6: return dig(w4, 5 - ki);
			SG_FIELD7: return (ki == 5) ? CH_DOT : ((ki == 6) ? dig(w4, 0) : dig(w4, 5 - ki));
			SG_MODE: return {6'b011000, w0[W0_MODE]};
			SG_TRUNC: return {6'b011000, w0[W0_TRUNC]};
			SG_STATUS: return {3'b011, w0[W0_STATUS_LSB +: 4]};
			SG_LAT: begin
				if (ki == 0) begin
					return w0[W0_LAT_NEG] ? CH_MINUS : CH_PLUS;
				end
				if (ki == 3) begin
					return CH_DOT;
				end
				return (ki < 3) ? dig(w7, 8 - ki) : dig(w7, 9 - ki);
			end
			SG_LON: begin
				if (ki == 0) begin
					return w0[W0_LON_NEG] ? CH_MINUS : CH_PLUS;
				end
				if (ki == 1) begin
					return {6'b011000, w0[W0_LON_HUND]};
				end
				if (ki == 4) begin
					return CH_DOT;
				end
				return (ki < 4) ? dig(w8, 9 - ki) : dig(w8, 10 - ki);
			end
			SG_PTIME: return sep8(w5, k, CH_COLON);
			SG_PDATE: return sep8(w6, k, CH_SLASH);
			SG_CRLF: return (ki == 0) ? CH_CR : CH_LF;
			default: return CH_SPACE;
		endcase
	endfunction : seg_char

	for (genvar i = 0; i < REC_WORDS; i++) begin : g_recw
		assign recw[i] = mem[{st.rec[2:0], 4'(i)}];
	end

	assign busy = (st.seq != SQ_IDLE) || st.tx_busy;
	assign s_axi_awready = !st.aw_ok && !st.bvalid;
	assign s_axi_wready = !st.w_ok && !st.bvalid;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign txd = st.tx_line;

	always_comb begin
		nx = st;
		mem_we = 1'b0;
		mem_widx = st.aw_addr[8:2];
		mem_wdata = merge(mem[st.aw_addr[8:2]], st.w_data, st.w_strb);
		start_req = 1'b0;
		merged = 32'h0;
		ch_valid = 1'b0;
		ch = CH_SPACE;
		kind = seg_at(st.csv, st.seg);
		len = seg_len(kind, recw[WD_FLAGS][W0_POS_VALID]);
		accept = 1'b0;

		// Write channel: address and data are taken independently, answered once both are in
		if (s_axi_awvalid && s_axi_awready) begin
			nx.aw_ok = 1'b1;
			nx.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nx.w_ok = 1'b1;
			nx.w_data = s_axi_wdata;
			nx.w_strb = s_axi_wstrb;
		end
		if (st.aw_ok && st.w_ok) begin
			nx.aw_ok = 1'b0;
			nx.w_ok = 1'b0;
			nx.bvalid = 1'b1;
			nx.bresp = RESP_OKAY;
			if (st.aw_addr[11:9] == MEM_SEL) begin
				mem_we = 1'b1;
			end else begin
				case (st.aw_addr)
					OFS_CTRL: begin
						merged = merge({30'h0, st.ctrl_seek, st.ctrl_csv}, st.w_data, st.w_strb);
						nx.ctrl_csv = merged[CTRL_CSV_BIT];
						nx.ctrl_seek = merged[CTRL_SEEK_BIT];
					end
					OFS_CMD: start_req = st.w_strb[0] && st.w_data[CMD_START_BIT] && !busy;
					OFS_START_STATION: begin
						merged = merge({20'h0, st.start_station}, st.w_data, st.w_strb);
						nx.start_station = merged[11:0];
					end
					OFS_RECORD_COUNT: begin
						merged = merge({28'h0, st.rec_count}, st.w_data, st.w_strb);
						nx.rec_count = (merged > 32'(RECS_MAX)) ? RECS_MAX : merged[3:0];
					end
					OFS_BAUD_DIV: begin
						merged = merge({16'h0, st.baud_div}, st.w_data, st.w_strb);
						nx.baud_div = (merged[15:0] == 16'h0000) ? 16'h0001 : merged[15:0];
					end
					OFS_STATUS: nx.bresp = RESP_OKAY;
					default: nx.bresp = RESP_DECERR;
				endcase
			end
		end
		if (st.bvalid && s_axi_bready) begin
			nx.bvalid = 1'b0;
		end

		// Read channel
		if (s_axi_arvalid && s_axi_arready) begin
			nx.rvalid = 1'b1;
			nx.rresp = RESP_OKAY;
			nx.rdata = 32'h0;
			if (s_axi_araddr[11:9] == MEM_SEL) begin
				nx.rdata = mem[s_axi_araddr[8:2]];
			end else begin
				case (s_axi_araddr)
					OFS_CTRL: nx.rdata = {30'h0, st.ctrl_seek, st.ctrl_csv};
					OFS_CMD: nx.rdata = 32'h0;
					OFS_START_STATION: nx.rdata = {20'h0, st.start_station};
					OFS_RECORD_COUNT: nx.rdata = {28'h0, st.rec_count};
					OFS_BAUD_DIV: nx.rdata = {16'h0, st.baud_div};
					OFS_STATUS: nx.rdata = {20'h0, st.rec, 5'h00, st.tx_line, cts, busy};
					default: nx.rresp = RESP_DECERR;
				endcase
			end
		end
		if (st.rvalid && s_axi_rready) begin
			nx.rvalid = 1'b0;
		end

		// Character producer
		case (st.seq)
			SQ_HDR1: begin
				ch_valid = 1'b1;
				ch = (int'(st.k) < HDR1_LEN) ? HDR1_TEXT[8*(HDR1_LEN-1-int'(st.k)) +: 7] :
					((int'(st.k) == HDR1_LEN) ? CH_CR : CH_LF);
			end
			SQ_HDR2: begin
				ch_valid = 1'b1;
				ch = (int'(st.k) < HDR2_LEN) ? HDR2_TEXT[8*(HDR2_LEN-1-int'(st.k)) +: 7] :
					((int'(st.k) == HDR2_LEN) ? CH_CR : CH_LF);
			end
			SQ_REC: begin
				ch_valid = (st.rec < st.rec_count) && (len != 4'h0);
				ch = seg_char(kind, st.k[3:0], recw[0], recw[1], recw[2], recw[3], recw[4], recw[5], recw[6],
					recw[7], recw[8]);
			end
			SQ_EOT: begin
				ch_valid = 1'b1;
				ch = CH_EOT;
			end
			default: ch_valid = 1'b0;
		endcase
		// Clear-to-send is sampled only between characters, so a frame is never cut short
		accept = ch_valid && !st.tx_busy && cts;

		// Dump sequencer
		case (st.seq)
			SQ_IDLE: begin
				if (start_req) begin
					nx.csv = st.ctrl_csv;
					nx.rec = 4'h0;
					nx.seg = 5'h00;
					nx.k = 8'h00;
					nx.seq = st.ctrl_seek ? SQ_SEEK : (st.ctrl_csv ? SQ_HDR1 : SQ_REC);
				end
			end
			SQ_SEEK: begin
				if ((st.rec >= st.rec_count) || (recw[WD_STN_JDAY][27:16] == st.start_station)) begin
					nx.seq = st.csv ? SQ_HDR1 : SQ_REC;
				end else begin
					nx.rec = st.rec + 4'h1;
				end
			end
			SQ_HDR1: begin
				if (accept) begin
					nx.k = st.k + 8'h01;
					if (int'(st.k) == HDR1_LEN + 1) begin
						nx.k = 8'h00;
						nx.seq = SQ_HDR2;
					end
				end
			end
			SQ_HDR2: begin
				if (accept) begin
					nx.k = st.k + 8'h01;
					if (int'(st.k) == HDR2_LEN + 1) begin
						nx.k = 8'h00;
						nx.seq = SQ_REC;
					end
				end
			end
			SQ_REC: begin
				if (st.rec >= st.rec_count) begin
					nx.seq = SQ_EOT;
				end else if (kind == SG_END) begin
					nx.rec = st.rec + 4'h1;
					nx.seg = 5'h00;
				end else if (len == 4'h0) begin
					nx.seg = st.seg + 5'h01;
				end else if (accept) begin
					nx.k = st.k + 8'h01;
					if (st.k[3:0] == len - 4'h1) begin
						nx.k = 8'h00;
						nx.seg = st.seg + 5'h01;
					end
				end
			end
			SQ_EOT: begin
				if (accept) begin
					nx.seq = SQ_IDLE;
				end
			end
			default: nx.seq = SQ_IDLE;
		endcase

		// Serial engine: eleven bit times per character, least significant data bit first
		if (st.tx_busy) begin
			nx.baud_cnt = st.baud_cnt + 16'h0001;
			if (st.baud_cnt >= st.baud_div - 16'h0001) begin
				nx.baud_cnt = 16'h0000;
				if (st.tx_left == 4'h0) begin
					nx.tx_busy = 1'b0;
					nx.tx_line = IDLE_LEVEL;
				end else begin
					nx.tx_shift = {1'b0, st.tx_shift[10:1]};
					nx.tx_line = st.tx_shift[1];
					nx.tx_left = st.tx_left - 4'h1;
				end
			end
		end else if (accept) begin
			nx.tx_busy = 1'b1;
			nx.tx_shift = {STOP_LEVEL, STOP_LEVEL, PARITY_LEVEL, ch, START_LEVEL};
			nx.tx_line = START_LEVEL;
			nx.tx_left = FRAME_LEFT;
			nx.baud_cnt = 16'h0000;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= ST_RESET;
		end else begin
			st <= nx;
		end
	end

	// Record store is plain data and keeps no reset value
	always_ff @(posedge aclk) begin
		if (mem_we) begin
			mem[mem_widx] <= mem_wdata;
		end
	end
endmodule : srt_tx

// ---- tb/srt_rx_model.sv ----
// Behavioural serial receiver standing in for the host on the transmit line
`timescale 1ns/1ps
module srt_rx_model (
	input wire logic aclk,
	input wire logic txd,
	input wire logic stall,
	input wire logic [15:0] div,
	output logic cts
);
	logic [6:0] chars[$];
	int bad_frames;
	logic [9:0] b;
	int i;
	// Host drops clear-to-send while it is busy
	assign cts = !stall;
	// Mid-bit sampling at the fixed bit time on its div input, so a drifting divisor shows up
	initial begin
		bad_frames = 0;
		forever begin
			@(posedge aclk);
			if (txd === 1'b1) begin
				repeat (div / 2) @(posedge aclk);
				if (txd !== 1'b1)
					bad_frames++;
				for (i = 0; i < 10; i++) begin
					repeat (div) @(posedge aclk);
					b[i] = txd;
				end
				if (b[9:7] !== 3'b000)
					bad_frames++;
				chars.push_back(b[6:0]);
			end
		end
	end
endmodule : srt_rx_model

// ---- tb/srt_tx_properties.sv ----
// Concurrent checks on the serial frame and the register bus of the transmitter
`timescale 1ns/1ps
module srt_tx_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [srt_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cts,
	input wire logic txd
);
	import srt_pkg::*;
	logic [11:0] wa;
	logic [31:0] wd;
	logic [15:0] div;
	logic [19:0] run;
	logic [19:0] flen;
	logic [19:0] pos;
	assign flen = 20'(div) * 20'd11;
	assign pos = (txd && run >= flen) ? 20'h0 : run;
	// Divisor is snooped from accepted writes so the frame checks follow the programmed bit time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div <= BAUD_DIV_RESET;
			run <= 20'hfffff;
		end else begin
			if (s_axi_awvalid && s_axi_awready)
				wa <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready)
				wd <= s_axi_wdata;
			if (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY && wa == OFS_BAUD_DIV)
				div <= (wd[15:0] == 16'h0) ? 16'h1 : wd[15:0];
			run <= (pos < flen) ? pos + 20'h1 : pos;
		end
	end
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_wr_answer;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	a_start_high: assert property (@(posedge aclk) disable iff (!aresetn) pos < 20'(div) |-> txd)
		else $error("start bit not high for a full bit time");
	a_parity_low: assert property (@(posedge aclk) disable iff (!aresetn)
		pos >= 20'(div) * 20'd8 && pos < 20'(div) * 20'd9 |-> !txd)
		else $error("parity bit not low");
	a_stop_low: assert property (@(posedge aclk) disable iff (!aresetn)
		pos >= 20'(div) * 20'd9 && pos < flen |-> !txd)
		else $error("stop bits not low");
	a_cts_holdoff: assert property (@(posedge aclk) disable iff (!aresetn)
		pos >= flen - 20'h1 && !cts |=> !txd)
		else $error("character started while clear-to-send low");
	a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn) s_wr_taken |=> s_wr_answer)
		else $error("write response not raised in the second cycle");
	a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not valid the cycle after the address");
	a_write_blocked: assert property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write channels ready while a response is pending");
	a_read_blocked: assert property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid |-> !s_axi_arready)
		else $error("read address ready while read data pending");
	a_resp_retire: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write response not retired after acceptance");
endmodule : srt_tx_props
bind srt_tx srt_tx_props u_srt_tx_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .cts, .txd);

// ---- tb/tb_srt_tx.sv ----
// Bench: register access, dumps in both layouts, station seek and flow control
`timescale 1ns/1ps
module tb_srt_tx;
	import srt_pkg::*;
	localparam logic [15:0] BDIV = 16'h0006;
	localparam string CRLF = "\015\012";
	localparam string EOT = "\004";
	localparam string L0 = {"*003 197 132802 0012 573428", CRLF};
	localparam string L1 = {" 004 198 091500 0034 498761", CRLF};
	localparam string C0 = {"1,00003,07/23/14,13:28:02,0012,0,57342.8,+37.399606,-121.889155,20:28:11,07/23/14,,5,", CRLF};
	localparam string C1 = {"0,00004,07/24/14,09:15:00,0034,1,49876.1,,,,,,0,", CRLF};
	localparam logic [31:0] RECW [2][9] = '{
		'{32'hd4b00003, 32'h00120197, 32'h00072314, 32'h00132802, 32'h00573428, 32'h00202811, 32'h00072314,
			32'h37399606, 32'h21889155},
		'{32'h20000004, 32'h00340198, 32'h00072414, 32'h00091500, 32'h00498761, 32'h0, 32'h0, 32'h0, 32'h0}};
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cts, txd, stall;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	int n_fail, n_tests, n0, r, w;
	srt_tx u_srt_tx (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cts, .txd);
	srt_rx_model u_srt_rx_model (.aclk, .txd, .stall, .div(BDIV), .cts);
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report
	// Address and data are offered together; each is released on its own acceptance
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
		logic aw_d;
		logic w_d;
		aw_d = 1'b0;
		w_d = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_d && w_d)) begin
			@(posedge aclk);
			if (!aw_d && s_axi_awready === 1'b1) begin
				aw_d = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_d && s_axi_wready === 1'b1) begin
				w_d = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		// One edge passes so a following write does not lower and raise bready in one step
		@(posedge aclk);
	endtask : axi_wr
	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1)
			@(posedge aclk);
		d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : axi_rd
	task automatic start_dump();
		u_srt_rx_model.chars.delete();
		u_srt_rx_model.bad_frames = 0;
		axi_wr(OFS_CMD, 32'h1, rsp);
	endtask : start_dump
	// Waits for the whole text, then a little longer so a stray extra character is caught
	task automatic finish_dump(input string exp);
		int i;
		while (u_srt_rx_model.chars.size() < exp.len())
			@(posedge aclk);
		repeat (12 * BDIV) @(posedge aclk);
		check("char count", u_srt_rx_model.chars.size(), exp.len());
		check("frame errors", u_srt_rx_model.bad_frames, 0);
		for (i = 0; i < exp.len(); i++)
			check("char", {25'h0, u_srt_rx_model.chars[i]}, 32'(exp[i]));
		axi_rd(OFS_STATUS, rd, rsp);
		check("busy after dump", {31'h0, rd[0]}, 32'h0);
	endtask : finish_dump
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	initial begin
		repeat (80000) @(posedge aclk);
		n_fail++;
		final_report();
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, stall} <= 7'h0;
		s_axi_awaddr <= 12'h000;
		s_axi_araddr <= 12'h000;
		s_axi_wdata <= 32'h0;
		s_axi_wstrb <= 4'hf;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(OFS_STATUS, rd, rsp);
		check("status reset", rd, 32'h00000002);
		axi_rd(OFS_BAUD_DIV, rd, rsp);
		check("divisor reset", rd, {16'h0, BAUD_DIV_RESET});
		axi_wr(OFS_RECORD_COUNT, 32'h9, rsp);
		axi_rd(OFS_RECORD_COUNT, rd, rsp);
		check("count clamp", rd, 32'h8);
		axi_rd(12'h100, rd, rsp);
		check("unmapped rresp", {30'h0, rsp}, {30'h0, RESP_DECERR});
		check("unmapped rdata", rd, 32'h0);
		axi_wr(12'h100, 32'h1, rsp);
		check("unmapped bresp", {30'h0, rsp}, {30'h0, RESP_DECERR});
		axi_wr(OFS_STATUS, 32'hffffffff, rsp);
		check("status write bresp", {30'h0, rsp}, {30'h0, RESP_OKAY});
		axi_rd(OFS_STATUS, rd, rsp);
		check("status read only", rd, 32'h00000002);
		// Byte strobes merge into the held value, so only the low byte may change
		s_axi_wstrb <= 4'h1;
		axi_wr(OFS_START_STATION, 32'h00000fff, rsp);
		s_axi_wstrb <= 4'hf;
		axi_rd(OFS_START_STATION, rd, rsp);
		check("strobe merge", rd, 32'h000000ff);
		for (r = 0; r < 2; r++)
			for (w = 0; w < 9; w++)
				axi_wr(12'(12'h200 + r * 64 + w * 4), RECW[r][w], rsp);
		axi_wr(OFS_BAUD_DIV, {16'h0, BDIV}, rsp);
		axi_wr(OFS_RECORD_COUNT, 32'h2, rsp);
		axi_wr(OFS_CTRL, 32'h0, rsp);
		start_dump();
		finish_dump({L0, L1, EOT});
		axi_wr(OFS_START_STATION, 32'h034, rsp);
		axi_wr(OFS_CTRL, 32'h2, rsp);
		start_dump();
		finish_dump({L1, EOT});
		axi_wr(OFS_CTRL, 32'h1, rsp);
		start_dump();
		axi_wr(OFS_CTRL, 32'h0, rsp);
		while (u_srt_rx_model.chars.size() < 40)
			@(posedge aclk);
		stall <= 1'b1;
		n0 = u_srt_rx_model.chars.size();
		repeat (400) @(posedge aclk);
		check("held chars", 32'(u_srt_rx_model.chars.size() - n0 <= 1), 32'h1);
		stall <= 1'b0;
		finish_dump({string'(HDR1_TEXT), CRLF, string'(HDR2_TEXT), CRLF, C0, C1, EOT});
		final_report();
	end
endmodule : tb_srt_tx
